// *** design/cjtr_result.sv ***
// Temperature result registers, alert limits and identity behind a pointer port
// How it works
// - Cold, delta, compensated result and raw converter registers all readable.
// - Compensated result equals delta value plus cold-junction value.
// - Result is 16-bit two's complement, LSB 0.0625 C, bit 14 1024 C.
// - Bit 15 of the result is the sign, set below zero.
// - Result is read-only, host writes ignored, zero after reset.
// - Cold input has its sign on bit 12, copied into bits 15..12; coarse mode clears two LSBs.
// - Delta input is 16-bit two's complement with sign on bit 15.
`timescale 1ns/1ps
module cjtr_result
   import cjtr_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic               conv_valid,
   input  wire logic [TEMP_W-1:0]  delta_in,
   input  wire logic [TEMP_W-1:0]  cold_in,
   input  wire logic               cold_coarse,
   input  wire logic [RAW_W-1:0]   raw_in,
   input  wire logic [7:0]         reg_ptr,
   input  wire logic               reg_wr,
   input  wire logic [TEMP_W-1:0]  reg_wdata,
   output logic      [RD_W-1:0]    reg_rdata_r
);
   logic signed [TEMP_W-1:0] delta_r;
   logic signed [TEMP_W-1:0] cold_r;
   logic        [RAW_W-1:0]  raw_r;
   logic                     load_d_r;
   logic signed [TEMP_W-1:0] sum_w;
   logic                     sum_valid_w;
   logic        [TEMP_W-1:0] comp_temp_r;
   logic        [HYST_W-1:0] alert_four_hysteresis_r;
   logic        [TEMP_W-1:0] alert_limit_r [4];
   logic        [RD_W-1:0]   rd_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [RD_W-1:0] ext16(input logic [TEMP_W-1:0] v);
      return {8'h00, v};
   endfunction

   function automatic logic [TEMP_W-1:0] cold_fmt(input logic [TEMP_W-1:0] v,
                                                  input logic              coarse);
      logic [TEMP_W-1:0] t;
      t = {{4{v[COLD_SIGN_LO]}}, v[COLD_SIGN_LO-1:0]};
      if (coarse) begin
         t[COARSE_BITS-1:0] = 2'b00;
      end
      return t;
   endfunction

   // ----------------------------------------
   // Operand capture
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         delta_r  <= TEMP_RST;
         cold_r   <= TEMP_RST;
         raw_r    <= RAW_RST;
         load_d_r <= 1'b0;
      end else begin
         load_d_r <= conv_valid;
         if (conv_valid) begin
            delta_r <= delta_in;
            cold_r  <= cold_fmt(cold_in, cold_coarse);
            raw_r   <= raw_in;
         end
      end
   end

   cjtr_adder u_adder (
      .core_clk (core_clk),
      .reset    (reset),
      .go       (load_d_r),
      .delta    (delta_r),
      .cold     (cold_r),
      .sum_r    (sum_w),
      .valid_r  (sum_valid_w)
   );

   // ----------------------------------------
   // Compensated result register
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         comp_temp_r <= TEMP_RST;
      end else if (sum_valid_w) begin
         comp_temp_r <= sum_w;
      end
   end

   // ----------------------------------------
   // Host writable registers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         alert_four_hysteresis_r <= HYST_RST;
         for (int i = 0; i < 4; i++) begin
            alert_limit_r[i] <= TEMP_RST;
         end
      end else if (reg_wr) begin
         if (reg_ptr == PTR_HYST4) begin
            alert_four_hysteresis_r <= reg_wdata[HYST_W-1:0];
         end
         for (int i = 0; i < 4; i++) begin
            if (reg_ptr == PTR_LIMIT1 + 8'(i)) begin
               alert_limit_r[i] <= reg_wdata & LIMIT_MASK;
            end
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb begin
      rd_nxt = '0;
      case (reg_ptr)
         PTR_COMP_TEMP: rd_nxt = ext16(comp_temp_r);
         PTR_DELTA:     rd_nxt = ext16(delta_r);
         PTR_COLD:      rd_nxt = ext16(cold_r);
         PTR_RAW:       rd_nxt = raw_r;
         PTR_HYST4:     rd_nxt = {16'h0000, alert_four_hysteresis_r};
         PTR_LIMIT1:    rd_nxt = ext16(alert_limit_r[0]);
         PTR_LIMIT2:    rd_nxt = ext16(alert_limit_r[1]);
         PTR_LIMIT3:    rd_nxt = ext16(alert_limit_r[2]);
         PTR_LIMIT4:    rd_nxt = ext16(alert_limit_r[3]);
         PTR_IDENT:     rd_nxt = ext16({PART_CODE, PART_REV});
         default:       rd_nxt = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata_r <= '0;
      end else begin
         reg_rdata_r <= rd_nxt;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_sum_latency;
      @(posedge core_clk) disable iff (reset)
      conv_valid |-> ##3 (comp_temp_r == 16'($past(delta_in, 3)
                          + $past(cold_fmt(cold_in, cold_coarse), 3)));
   endproperty
   a_sum_latency: assert property (p_sum_latency) else $error("sum wrong");

   property p_sign;
      @(posedge core_clk) disable iff (reset)
      sum_valid_w |=> comp_temp_r[SIGN_BIT]
                      == ((int'($past(delta_r, 2)) + int'($past(cold_r, 2))) < 0);
   endproperty
   a_sign: assert property (p_sign) else $error("sign bit wrong");

   property p_step;
      @(posedge core_clk) disable iff (reset)
      sum_valid_w |=> comp_temp_r == 16'($past(delta_r, 2) + $past(cold_r, 2));
   endproperty
   a_step: assert property (p_step) else $error("weights differ");

   property p_hold;
      @(posedge core_clk) disable iff (reset)
      !sum_valid_w |=> $stable(comp_temp_r);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved without sum");

   property p_reset_zero;
      @(posedge core_clk) disable iff (reset)
      $fell(reset) |-> (comp_temp_r == TEMP_RST) && (reg_rdata_r == '0);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("result not zero");

   property p_cold_fmt;
      @(posedge core_clk) disable iff (reset)
      conv_valid && cold_coarse |=> (cold_r[1:0] == 2'b00)
                   && ((&cold_r[15:12]) || !(|cold_r[15:12]));
   endproperty
   a_cold_fmt: assert property (p_cold_fmt) else $error("cold format bad");

   property p_delta_read;
      @(posedge core_clk) disable iff (reset)
      (reg_ptr == PTR_DELTA) |=> reg_rdata_r == ext16($past(delta_r));
   endproperty
   a_delta_read: assert property (p_delta_read) else $error("delta readback");

   property p_read_result;
      @(posedge core_clk) disable iff (reset)
      reg_ptr == PTR_COMP_TEMP |=> reg_rdata_r == ext16($past(comp_temp_r));
   endproperty
   a_read_result: assert property (p_read_result) else $error("result readback");

   property p_ro_ignore;
      @(posedge core_clk) disable iff (reset)
      reg_wr && (reg_ptr == PTR_COMP_TEMP) && !sum_valid_w |=> $stable(comp_temp_r);
   endproperty
   a_ro_ignore: assert property (p_ro_ignore) else $error("result took a write");

   property p_cold_sign;
      @(posedge core_clk) disable iff (reset)
      conv_valid |=> (&cold_r[SIGN_BIT:COLD_SIGN_LO]) || !(|cold_r[SIGN_BIT:COLD_SIGN_LO]);
   endproperty
   a_cold_sign: assert property (p_cold_sign) else $error("cold sign bits differ");

   property p_fine_keep;
      @(posedge core_clk) disable iff (reset)
      conv_valid && !cold_coarse |=> cold_r[1:0] == $past(cold_in[1:0]);
   endproperty
   a_fine_keep: assert property (p_fine_keep) else $error("fine cold bits lost");

   property p_delta_capture;
      @(posedge core_clk) disable iff (reset)
      conv_valid |=> delta_r == $past(delta_in);
   endproperty
   a_delta_capture: assert property (p_delta_capture) else $error("delta not captured");

   property p_raw_capture;
      @(posedge core_clk) disable iff (reset)
      conv_valid |=> raw_r == $past(raw_in);
   endproperty
   a_raw_capture: assert property (p_raw_capture) else $error("raw not captured");
endmodule

// *** design/cjtr_pkg.sv ***
// Register pointers, field positions, reset values and widths of the result block
package cjtr_pkg;
   localparam int          TEMP_W        = 16;
   localparam int          RAW_W         = 24;
   localparam int          RD_W          = 24;
   localparam int          HYST_W        = 8;
   localparam logic [7:0]  PTR_COMP_TEMP = 8'h00;
   localparam logic [7:0]  PTR_DELTA     = 8'h01;
   localparam logic [7:0]  PTR_COLD      = 8'h02;
   localparam logic [7:0]  PTR_RAW       = 8'h03;
   localparam logic [7:0]  PTR_HYST4     = 8'h0f;
   localparam logic [7:0]  PTR_LIMIT1    = 8'h10;
   localparam logic [7:0]  PTR_LIMIT2    = 8'h11;
   localparam logic [7:0]  PTR_LIMIT3    = 8'h12;
   localparam logic [7:0]  PTR_LIMIT4    = 8'h13;
   localparam logic [7:0]  PTR_IDENT     = 8'h20;
   localparam int          SIGN_BIT      = 15;
   localparam int          COLD_SIGN_LO  = 12;
   localparam int          COARSE_BITS   = 2;
   localparam logic [15:0] LIMIT_MASK    = 16'hfffc;
   localparam logic [15:0] TEMP_RST      = 16'h0000;
   localparam logic [23:0] RAW_RST       = 24'h000000;
   localparam logic [7:0]  HYST_RST      = 8'h00;
   // Identity values are arbitrary
   localparam logic [7:0]  PART_CODE     = 8'h5a;
   localparam logic [7:0]  PART_REV      = 8'h11;
endpackage

// *** design/cjtr_adder.sv ***
// Registered signed adder that forms the compensated temperature
`timescale 1ns/1ps
module cjtr_adder
   import cjtr_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     reset,
   input  wire logic                     go,
   input  wire logic signed [TEMP_W-1:0] delta,
   input  wire logic signed [TEMP_W-1:0] cold,
   output logic signed [TEMP_W-1:0]      sum_r,
   output logic                          valid_r
);
   // ----------------------------------------
   // Sum and completion flag
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sum_r   <= TEMP_RST;
         valid_r <= 1'b0;
      end else begin
         valid_r <= go;
         if (go) begin
            sum_r <= delta + cold;
         end
      end
   end
endmodule

// *** tb/cjtr_host.sv ***
// Host controller model on the register pointer port
`timescale 1ns/1ps
module cjtr_host
   import cjtr_pkg::*;
(
   input  wire logic              core_clk,
   output logic      [7:0]        reg_ptr,
   output logic                   reg_wr,
   output logic      [TEMP_W-1:0] reg_wdata,
   input  wire logic [RD_W-1:0]   reg_rdata_r
);
   initial begin
      reg_ptr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end
   // Write strobe for one cycle
   task automatic wr(input logic [7:0] p, input logic [TEMP_W-1:0] d);
      @(negedge core_clk);
      reg_ptr = p;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // Read data follows the pointer by one edge
   task automatic rd(input logic [7:0] p, output logic [RD_W-1:0] d);
      @(negedge core_clk);
      reg_ptr = p;
      @(negedge core_clk);
      d = reg_rdata_r;
   endtask
   // Temperature in sixteenths of a degree
   function automatic int decode(input logic [15:0] w);
      decode = w[15:8] * 256 + w[7:0] - (w[15] ? 65536 : 0);
   endfunction
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the result register block
`timescale 1ns/1ps
module testbench
   import cjtr_pkg::*;
;
   logic              core_clk = 1'b0;
   logic              reset = 1'b1;
   logic              conv_valid = 1'b0;
   logic [TEMP_W-1:0] delta_in = 16'h0000;
   logic [TEMP_W-1:0] cold_in = 16'h0000;
   logic              cold_coarse = 1'b0;
   logic [RAW_W-1:0]  raw_in = 24'h000000;
   logic [7:0]        reg_ptr;
   logic              reg_wr;
   logic [TEMP_W-1:0] reg_wdata;
   logic [RD_W-1:0]   reg_rdata_r;
   logic [RD_W-1:0]   got;
   logic [31:0]       seed = 32'h0446;
   int                num_errors = 0;
   int                compares = 0;
   always #2.5 core_clk = ~core_clk;
   cjtr_result dut (.core_clk(core_clk), .reset(reset), .conv_valid(conv_valid),
      .delta_in(delta_in), .cold_in(cold_in), .cold_coarse(cold_coarse), .raw_in(raw_in),
      .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));
   cjtr_host host (.core_clk(core_clk), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [15:0] cold_eff(input logic [15:0] c, input logic k);
      return {{4{c[12]}}, c[11:2], k ? 2'b00 : c[1:0]};
   endfunction
   task automatic check(input string n, input logic [RD_W-1:0] e, input logic [RD_W-1:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input string n, input logic [7:0] p, input logic [RD_W-1:0] e);
      host.rd(p, got);
      check(n, e, got);
   endtask
   task automatic convert(input logic [15:0] d, input logic [15:0] c, input logic k);
      logic [15:0] ce;
      logic [15:0] s;
      int          e;
      ce = cold_eff(c, k);
      s = d + ce;
      e = int'($signed(d)) + int'($signed(ce));
      @(negedge core_clk);
      delta_in = d;
      cold_in = c;
      cold_coarse = k;
      raw_in = {seed[7:0], d};
      conv_valid = 1'b1;
      @(negedge core_clk);
      conv_valid = 1'b0;
      delta_in = ~d;
      cold_in = ~c;
      raw_in = ~raw_in;
      repeat (3) @(negedge core_clk);
      rdchk("result", PTR_COMP_TEMP, {8'h00, s});
      check("decoded", 24'(e), 24'(host.decode(got[15:0])));
      check("sign", {23'h0, e < 0}, {23'h0, got[SIGN_BIT]});
      rdchk("delta", PTR_DELTA, {8'h00, d});
      rdchk("cold", PTR_COLD, {8'h00, ce});
      rdchk("raw", PTR_RAW, {seed[7:0], d});
      host.wr(PTR_COMP_TEMP, ~s);
      rdchk("result kept", PTR_COMP_TEMP, {8'h00, s});
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      summarize();
   end
   initial begin
      logic [15:0] cd [3];
      logic [15:0] cc [3];
      cd = '{16'h0010, 16'h0000, 16'hc000};
      cc = '{16'hfff0, 16'hffff, 16'hf000};
      repeat (8) @(negedge core_clk);
      reset = 1'b0;
      rdchk("reset result", PTR_COMP_TEMP, 24'h000000);
      rdchk("identity", PTR_IDENT, {8'h00, PART_CODE, PART_REV});
      for (int i = 0; i < 3; i++) convert(cd[i], cc[i], i[0]);
      for (int i = 0; i < 20; i++) begin
         seed = xorshift(seed);
         convert({seed[14], seed[14:0]}, seed[31:16], seed[20]);
      end
      @(negedge core_clk);
      delta_in = 16'h0100;
      cold_in = 16'h0020;
      conv_valid = 1'b1;
      @(negedge core_clk);
      delta_in = 16'hff00;
      @(negedge core_clk);
      conv_valid = 1'b0;
      repeat (3) @(negedge core_clk);
      rdchk("back to back", PTR_COMP_TEMP, 24'h00ff20);
      for (int i = 0; i < 4; i++) begin
         seed = xorshift(seed);
         host.wr(PTR_LIMIT1 + 8'(i), seed[15:0]);
         rdchk("limit", PTR_LIMIT1 + 8'(i), {8'h00, seed[15:0] & LIMIT_MASK});
      end
      host.wr(PTR_HYST4, seed[31:16]);
      rdchk("hyst", PTR_HYST4, {16'h0000, seed[23:16]});
      host.wr(8'h30, seed[15:0]);
      rdchk("unmapped", 8'h30, 24'h000000);
      @(negedge core_clk);
      reset = 1'b1;
      @(negedge core_clk);
      reset = 1'b0;
      rdchk("rereset result", PTR_COMP_TEMP, 24'h000000);
      summarize();
   end
endmodule
